// ---- prio_intc_cfg.svh ----
// Purpose: Offsets, field positions, reset values for the interrupt block
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   Included by the top module and the testbench
`ifndef PRIO_INTC_CFG_SVH
`define PRIO_INTC_CFG_SVH
`define OFS_TIMER_CONTROL   8'h88
`define OFS_ENABLE_A        8'h00
`define OFS_ENABLE_B        8'h04
`define OFS_PRIO_LOW_A      8'h08
`define OFS_PRIO_HIGH_A     8'h0C
`define OFS_PRIO_LOW_B      8'h10
`define OFS_PRIO_HIGH_B     8'h14
`define OFS_STATUS          8'h18
`define OFS_MASK            8'h1C
`define OFS_PENDING         8'h20
`define RST_TIMER_CONTROL   8'h00
`define RST_BYTE            8'h00
`define BIT_EXT_A_TYPE      0
`define BIT_EXT_A_FLAG      1
`define BIT_EXT_B_TYPE      2
`define BIT_EXT_B_FLAG      3
`define BIT_GLOBAL_EN       7
`define NUM_SOURCES         13
`define AXI_OKAY            2'b00
`define AXI_SLVERR          2'b10
`endif

// ---- prio_intc_pkg.sv ----
// Purpose: Types shared by the interrupt controller
// Assumes: Thirteen sources, four levels
// Notes:   Constants live in prio_intc_cfg.svh
package prio_intc_pkg;
  typedef logic [12:0] src_vec_t;
  typedef logic [1:0]  level_t;
  typedef struct packed {
    logic   valid;
    logic   [3:0] id;
    level_t level;
  } grant_t;
  typedef struct packed {
    logic   active;
    level_t level;
  } nest_t;
  typedef enum logic [1:0] {RUN, IDLE, PDOWN} pmode_t;
endpackage

// ---- prio_intc.sv ----
// What this block does
// - Accepts thirteen request sources incl two pins
// - Per-source enable bits gate every request
// - Global enable bit blocks all service
// - Two priority bits select one of four levels
// - Preempt only for strictly higher priority
// - Top-level routine is never preempted
// - Evaluate at instruction start, higher level first
// - Fixed polling order breaks ties within level
// - Type bit selects level or edge per pin
// - Edge mode flags high-then-low samples
// - Enabled external request wakes from low power
// - Timer control layout at 88H, reset zero
// - Any enabled request terminates Idle
//
// Purpose: Four-level priority interrupt controller with AXI4-Lite regs
// Assumes: Sources 0 and 1 are the two external pins; others are levels
//          from same-clock peripherals
// Notes:   Enter at ackTake with the reported vector; leave at retStrobe
`timescale 1ns/10ps
`include "prio_intc_cfg.svh"
module prio_intc
  import prio_intc_pkg::*;
#(
  parameter int NSRC = `NUM_SOURCES
) (
  input  wire logic        core_clk,     // 20 MHz core clock
  input  wire logic        rst_n,        // Synchronous reset, active low
  input  wire logic [1:0]  extPin,       // External request pins
  input  wire logic [12:2] periphReq,    // Peripheral request levels
  input  wire logic        instrStart,   // Instruction boundary pulse
  input  wire logic        ackTake,      // Core enters offered vector
  input  wire logic        retStrobe,    // Core returns from routine
  input  wire logic        sleepIdle,    // Core enters Idle pulse
  input  wire logic        sleepPdown,   // Core enters Power-down pulse
  output logic             intReq,       // Service request to core
  output logic [3:0]       intId,        // Source to service
  output logic [1:0]       intLevel,     // Level of offered source
  output logic             wakeUp,       // Wake pulse to clock logic
  output logic             irq,          // Masked sticky status irq
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge sampling
  logic [1:0] pinMeta, pinSync, pinPrev;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pinMeta <= 2'h3;
      pinSync <= 2'h3;
      pinPrev <= 2'h3;
    end else begin
      pinMeta <= extPin;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end
  logic [1:0] fallEdge;
  assign fallEdge = pinPrev & ~pinSync;

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]  timer_control_reg, enA, enB, plA, phA, plB, phB;
  src_vec_t    status, mask;
  logic [7:0]  next_timer_control_reg, next_enA, next_enB, next_plA, next_phA;
  logic [7:0]  next_plB, next_phB;
  src_vec_t    next_status, next_mask;
  logic        awHeld, wHeld, next_awHeld, next_wHeld;
  logic [7:0]  awA, next_awA;
  logic [31:0] wD, next_wD;
  logic [3:0]  wS, next_wS;
  logic        bV, next_bV, rV, next_rV;
  logic [1:0]  bR, next_bR, rR, next_rR;
  logic [31:0] rD, next_rD;

  // Request vector built from pins and peripherals
  src_vec_t req, enVec;
  logic [1:0] extType;
  assign extType = {timer_control_reg[`BIT_EXT_B_TYPE], timer_control_reg[`BIT_EXT_A_TYPE]};
  always_comb begin
    req[12:2] = periphReq;
    for (int i = 0; i < 2; i++) begin
      // Edge mode uses the flag, level mode follows low pin
      req[i] = extType[i] ? timer_control_reg[2*i+1] : ~pinSync[i];
    end
  end
  assign enVec = {enB[5:0], enA[6:0]};

  // Level of a source from its low and high priority bits
  function automatic level_t srcLevel(input int s, input logic [7:0] la,
      input logic [7:0] ha, input logic [7:0] lb, input logic [7:0] hb);
    level_t l;
    l = (s < 7) ? {ha[s], la[s]} : {hb[s-7], lb[s-7]};
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Arbitration
  grant_t best;
  src_vec_t live;
  assign live = req & enVec & {NSRC{enA[`BIT_GLOBAL_EN]}};
  always_comb begin
    level_t lv;
    lv = 2'h0;
    best = '0;
    // Scan in fixed rank; only a strictly higher level displaces
    for (int s = 0; s < NSRC; s++) begin
      lv = srcLevel(s, plA, phA, plB, phB);
      if (live[s] && (!best.valid || lv > best.level)) begin
        best.valid = 1'b1;
        best.id    = 4'(s);
        best.level = lv;
      end
    end
  end

  // Nesting stack of active levels, one slot per level
  nest_t [3:0] stack, next_stack;
  logic [2:0]  depth, next_depth;
  nest_t       top;
  assign top = (depth == 3'h0) ? '0 : stack[depth[1:0] - 2'h1];
  logic canPreempt;
  assign canPreempt = best.valid &&
    (!top.active || (top.level != 2'h3 && best.level > top.level));

  logic   offer, next_offer;
  logic [3:0] next_id;
  level_t next_lvl;
  always_comb begin
    next_stack = stack;
    next_depth = depth;
    next_offer = offer;
    next_id    = intId;
    next_lvl   = intLevel;
    if (ackTake && offer && depth < 3'h4) begin
      next_stack[depth[1:0]] = '{active: 1'b1, level: intLevel};
      next_depth = depth + 3'h1;
      next_offer = 1'b0;
    end else if (retStrobe && depth != 3'h0) begin
      next_stack[depth[1:0] - 2'h1] = '0;
      next_depth = depth - 3'h1;
      next_offer = 1'b0;
    end else if (instrStart) begin
      next_offer = canPreempt;
      next_id    = best.id;
      next_lvl   = best.level;
    end
  end

  // Low power mode tracking
  pmode_t pm, next_pm;
  logic   next_wake;
  always_comb begin
    next_pm   = pm;
    next_wake = 1'b0;
    if (sleepIdle) next_pm = IDLE;
    else if (sleepPdown) next_pm = PDOWN;
    case (pm)
      IDLE: if (|live) begin
        next_pm = RUN;
        next_wake = 1'b1;
      end
      PDOWN: if (|live[1:0]) begin
        next_pm = RUN;
        next_wake = 1'b1;
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and register writes
  logic doWr, doRd, hit;
  assign doWr = (awHeld || s_axi_awvalid) && (wHeld || s_axi_wvalid) && !bV;
  assign doRd = s_axi_arvalid && !rV;
  function automatic logic [7:0] merge(input logic [7:0] o,
      input logic [31:0] d, input logic [3:0] s);
    return s[0] ? d[7:0] : o;
  endfunction
  always_comb begin
    logic [7:0]  a;
    logic [31:0] d;
    logic [3:0]  st;
    a  = awHeld ? awA : s_axi_awaddr;
    d  = wHeld ? wD : s_axi_wdata;
    st = wHeld ? wS : s_axi_wstrb;
    next_awHeld = awHeld;
    next_wHeld  = wHeld;
    next_awA = awA;
    next_wD  = wD;
    next_wS  = wS;
    next_bV  = bV && !s_axi_bready;
    next_bR  = bR;
    next_rV  = rV && !s_axi_rready;
    next_rR  = rR;
    next_rD  = rD;
    next_timer_control_reg = timer_control_reg;
    next_enA = enA;
    next_enB = enB;
    next_plA = plA;
    next_phA = phA;
    next_plB = plB;
    next_phB = phB;
    next_mask = mask;
    next_status = status;
    hit = 1'b1;
    if (s_axi_awvalid && !awHeld) begin
      next_awHeld = 1'b1;
      next_awA = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld) begin
      next_wHeld = 1'b1;
      next_wD = s_axi_wdata;
      next_wS = s_axi_wstrb;
    end
    if (doWr) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bV = 1'b1;
      case (a)
        `OFS_TIMER_CONTROL: next_timer_control_reg = merge(timer_control_reg, d, st);
        `OFS_ENABLE_A:   next_enA = merge(enA, d, st);
        `OFS_ENABLE_B:   next_enB = merge(enB, d, st);
        `OFS_PRIO_LOW_A: next_plA = merge(plA, d, st);
        `OFS_PRIO_HIGH_A: next_phA = merge(phA, d, st);
        `OFS_PRIO_LOW_B: next_plB = merge(plB, d, st);
        `OFS_PRIO_HIGH_B: next_phB = merge(phB, d, st);
        `OFS_MASK: if (st[0] && st[1]) next_mask = d[12:0];
        `OFS_STATUS, `OFS_PENDING: ;
        default: hit = 1'b0;
      endcase
      next_bR = hit ? `AXI_OKAY : `AXI_SLVERR;
    end
    if (doRd) begin
      next_rV = 1'b1;
      next_rR = `AXI_OKAY;
      case (s_axi_araddr)
        `OFS_TIMER_CONTROL: next_rD = {24'h00_0000, timer_control_reg};
        `OFS_ENABLE_A:   next_rD = {24'h00_0000, enA};
        `OFS_ENABLE_B:   next_rD = {24'h00_0000, enB};
        `OFS_PRIO_LOW_A: next_rD = {24'h00_0000, plA};
        `OFS_PRIO_HIGH_A: next_rD = {24'h00_0000, phA};
        `OFS_PRIO_LOW_B: next_rD = {24'h00_0000, plB};
        `OFS_PRIO_HIGH_B: next_rD = {24'h00_0000, phB};
        `OFS_MASK:       next_rD = {19'h0_0000, mask};
        `OFS_PENDING:    next_rD = {19'h0_0000, req};
        `OFS_STATUS: begin
          next_rD = {19'h0_0000, status};
          next_status = '0;
        end
        default: begin
          next_rD = 32'h0000_0000;
          next_rR = `AXI_SLVERR;
        end
      endcase
    end
    // Pin edges set flags; a set wins over a write in the same cycle
    for (int i = 0; i < 2; i++) begin
      if (extType[i] && fallEdge[i]) next_timer_control_reg[2*i+1] = 1'b1;
    end
    // Flag cleared by hardware when edge source is entered
    if (ackTake && offer && intId < 4'h2 && extType[intId[0]] &&
        !(fallEdge[intId[0]]))
      next_timer_control_reg[2*intId[0]+1] = 1'b0;
    next_status = next_status | req; // Set beats the read clear
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timer_control_reg <= `RST_TIMER_CONTROL;
      enA <= `RST_BYTE;
      enB <= `RST_BYTE;
      plA <= `RST_BYTE;
      phA <= `RST_BYTE;
      plB <= `RST_BYTE;
      phB <= `RST_BYTE;
      status <= '0;
      mask <= '0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awA <= 8'h00;
      wD <= 32'h0000_0000;
      wS <= 4'h0;
      bV <= 1'b0;
      bR <= 2'b00;
      rV <= 1'b0;
      rR <= 2'b00;
      rD <= 32'h0000_0000;
      stack <= '0;
      depth <= 3'h0;
      offer <= 1'b0;
      intId <= 4'h0;
      intLevel <= 2'h0;
      pm <= RUN;
      wakeUp <= 1'b0;
      irq <= 1'b0;
    end else begin
      timer_control_reg <= next_timer_control_reg;
      enA <= next_enA;
      enB <= next_enB;
      plA <= next_plA;
      phA <= next_phA;
      plB <= next_plB;
      phB <= next_phB;
      status <= next_status;
      mask <= next_mask;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awA <= next_awA;
      wD <= next_wD;
      wS <= next_wS;
      bV <= next_bV;
      bR <= next_bR;
      rV <= next_rV;
      rR <= next_rR;
      rD <= next_rD;
      stack <= next_stack;
      depth <= next_depth;
      offer <= next_offer;
      intId <= next_id;
      intLevel <= next_lvl;
      pm <= next_pm;
      wakeUp <= next_wake;
      irq <= |(next_status & next_mask);
    end
  end

  // Bus outputs straight from flops
  assign intReq        = offer;
  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign s_axi_bvalid  = bV;
  assign s_axi_bresp   = bR;
  assign s_axi_arready = !rV;
  assign s_axi_rvalid  = rV;
  assign s_axi_rresp   = rR;
  assign s_axi_rdata   = rD;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_global_off_block: assert property (instrStart && !enA[7] |=> !intReq)
    else $error("offer while global enable off");
  a_enable_gates: assert property (intReq |-> enVec[intId])
    else $error("disabled source offered");
  a_top_level_keep: assert property (instrStart && top.active &&
    top.level == 2'h3 |=> !intReq)
    else $error("top level routine preempted");
  a_strict_preempt: assert property (intReq && top.active |->
    intLevel > top.level)
    else $error("preempt not strictly higher");
  a_edge_sets_flag: assert property (extType[0] && fallEdge[0] |=>
    timer_control_reg[1])
    else $error("edge flag not set");
  a_level_follow: assert property (!extType[0] |-> req[0] == !pinSync[0])
    else $error("level request mismatch");
  a_idle_wakes: assert property (pm == IDLE && |live |=> wakeUp)
    else $error("idle not ended");
  a_pdown_wakes: assert property (pm == PDOWN && |live[1:0] |=> wakeUp)
    else $error("power-down not ended");
  a_higher_first: assert property (instrStart && best.valid && !top.active &&
    !ackTake && !retStrobe
    |=> intReq && intLevel == $past(best.level))
    else $error("higher level not chosen");
  a_rank_tie: assert property (instrStart && live[0] && live[1] &&
    srcLevel(0, plA, phA, plB, phB) == srcLevel(1, plA, phA, plB, phB) &&
    !top.active && srcLevel(0, plA, phA, plB, phB) >= best.level &&
    !ackTake && !retStrobe
    |=> intId == 4'h0)
    else $error("tie not by rank");
  c_nested: cover property (depth == 3'h2);
  c_wake: cover property (wakeUp);
  c_edge: cover property (fallEdge[1] && extType[1]);
  c_status_read: cover property (doRd && s_axi_araddr == `OFS_STATUS);
endmodule

// ---- core_model.sv ----
// Purpose: Behavioural CPU core on the far side of the controller
// Assumes: An instruction boundary every fourth cycle while run is high
// Notes:   Enters every standing offer at once; returns on retCmd
`timescale 1ns/10ps
module core_model
  import prio_intc_pkg::*;
(
  input  wire logic       core_clk,   // Core clock
  input  wire logic       rst_n,      // Sync reset, active low
  input  wire logic       intReq,     // Offer standing
  input  wire logic [3:0] intId,      // Offered source
  input  wire logic [1:0] intLevel,   // Offered level
  input  wire logic       run,        // Execute instructions
  input  wire logic       retCmd,     // Finish current routine
  output logic            instrStart, // Boundary pulse
  output logic            ackTake,    // Enter offered vector
  output logic            retStrobe,  // Return pulse
  output logic [3:0]      takenId,    // Last entered source
  output level_t          takenLevel, // Last entered level
  output logic [7:0]      takenCnt    // Entries so far
);
  logic [1:0] phase;

  ////////////////////////////////////////////////////////////////////////
  // Boundaries, entry and return; entry recorded at the taking edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase      <= 2'h0;
      instrStart <= 1'b0;
      ackTake    <= 1'b0;
      retStrobe  <= 1'b0;
      takenId    <= 4'h0;
      takenLevel <= 2'h0;
      takenCnt   <= 8'h00;
    end else begin
      phase      <= phase + 2'h1;
      instrStart <= run && (phase == 2'h3);
      ackTake    <= intReq && !ackTake;
      retStrobe  <= retCmd;
      if (ackTake && intReq) begin
        takenId    <= intId;
        takenLevel <= intLevel;
        takenCnt   <= takenCnt + 8'h01;
      end
    end
  end
endmodule

// ---- tb_prio_intc.sv ----
// Purpose: Self-checking bench for the priority interrupt controller
// Assumes: Core model enters offers at once; registers over AXI4-Lite
// Notes:   Every scenario starts from a fresh reset
`timescale 1ns/10ps
`include "prio_intc_cfg.svh"
module tb_prio_intc;
  import prio_intc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  extPin = 2'b11;
  logic [12:2] periphReq = '0;
  logic        sleepIdle = 1'b0, sleepPdown = 1'b0, run = 1'b0;
  logic        retCmd = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rr, br;
  logic        instrStart, ackTake, retStrobe, intReq, wakeUp, irq;
  logic [3:0]  intId, takenId;
  logic [1:0]  intLevel;
  level_t      takenLevel;
  logic [7:0]  takenCnt, wakeCnt;
  int          badCount = 0, testsRun = 0;

  always #25 core_clk = ~core_clk;

  prio_intc uut (.core_clk(core_clk), .rst_n(rst_n), .extPin(extPin),
    .periphReq(periphReq), .instrStart(instrStart), .ackTake(ackTake),
    .retStrobe(retStrobe), .sleepIdle(sleepIdle), .sleepPdown(sleepPdown),
    .intReq(intReq), .intId(intId), .intLevel(intLevel), .wakeUp(wakeUp),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  core_model core (.core_clk(core_clk), .rst_n(rst_n), .intReq(intReq),
    .intId(intId), .intLevel(intLevel), .run(run), .retCmd(retCmd),
    .instrStart(instrStart), .ackTake(ackTake), .retStrobe(retStrobe),
    .takenId(takenId), .takenLevel(takenLevel), .takenCnt(takenCnt));

  // Wake pulse counter
  always_ff @(posedge core_clk) begin
    if (!rst_n) wakeCnt <= 8'h00;
    else if (wakeUp) wakeCnt <= wakeCnt + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      badCount++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    periphReq <= '0;
    extPin <= 2'b11;
    run <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask

  task automatic set_req(input src_vec_t v, input logic r);
    @(posedge core_clk);
    periphReq <= v[12:2];
    extPin <= ~v[1:0];
    run <= r;
  endtask

  task automatic ret_pulse;
    @(posedge core_clk);
    retCmd <= 1'b1;
    @(posedge core_clk);
    retCmd <= 1'b0;
  endtask

  // Bounded wait until the core has entered n routines
  task automatic wait_take(input logic [7:0] n);
    repeat (100) begin
      @(negedge core_clk);
      if (takenCnt >= n) break;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw, tb;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge core_clk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge core_clk);
      if (ta) begin awvalid <= 1'b0; pa = 1'b0; end
      if (tw) begin wvalid <= 1'b0; pw = 1'b0; end
    end
    bready <= 1'b1;
    do begin
      @(negedge core_clk);
      tb = bvalid;
      br = bresp;
      @(posedge core_clk);
    end while (!tb);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic t;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge core_clk);
      t = arready;
      @(posedge core_clk);
    end while (!t);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(negedge core_clk);
      t = rvalid;
      rd = rdata;
      rr = rresp;
      @(posedge core_clk);
    end while (!t);
    rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Timer control reset value, unmapped access, then every source alone
  task automatic t_sources;
    src_vec_t v;
    axi_rd(`OFS_TIMER_CONTROL);
    check("timer_control_reg reset", rd, 32'h0000_0000);
    axi_rd(8'h40);
    check("unmapped resp", 32'(rr), 32'(`AXI_SLVERR));
    axi_wr(8'h40, 32'h0000_00FF);
    check("unmapped wr resp", 32'(br), 32'(`AXI_SLVERR));
    axi_wr(`OFS_PRIO_LOW_A, 32'h0000_0000);
    check("mapped wr resp", 32'(br), 32'(`AXI_OKAY));
    for (int s = 0; s < 13; s++) begin
      do_reset();
      v = src_vec_t'(1) << s;
      axi_wr(`OFS_ENABLE_A, {24'h0, 1'b1, v[6:0]});
      axi_wr(`OFS_ENABLE_B, {26'h0, v[12:7]});
      set_req(v, 1'b1);
      wait_take(8'h01);
      check("source taken", 32'(takenId), s);
    end
  endtask

  // Global and per-source enables
  task automatic t_enable;
    set_req(src_vec_t'(13'h0020), 1'b1);
    axi_wr(`OFS_ENABLE_A, 32'h0000_0020);
    idle(20);
    check("global off", 32'(takenCnt), 32'h0000_0000);
    axi_wr(`OFS_ENABLE_A, 32'h0000_00C0);
    idle(20);
    check("source off", 32'(takenCnt), 32'h0000_0000);
  endtask

  // Higher level first, then lowest index among equals
  task automatic t_prio;
    axi_wr(`OFS_ENABLE_A, 32'h0000_00D8);
    axi_wr(`OFS_ENABLE_B, 32'h0000_0004);
    axi_wr(`OFS_PRIO_LOW_A, 32'h0000_0008);
    axi_wr(`OFS_PRIO_HIGH_B, 32'h0000_0004);
    set_req(src_vec_t'(13'h0258), 1'b1);
    wait_take(8'h01);
    check("top level id", 32'(takenId), 32'h0000_0009);
    check("top level", 32'(takenLevel), 32'h0000_0002);
    set_req(src_vec_t'(13'h0058), 1'b1);
    ret_pulse();
    wait_take(8'h02);
    check("next level id", 32'(takenId), 32'h0000_0003);
    set_req(src_vec_t'(13'h0050), 1'b1);
    ret_pulse();
    wait_take(8'h03);
    check("tie id", 32'(takenId), 32'h0000_0004);
  endtask

  // Nesting: only strictly higher preempts, level three never
  task automatic t_preempt;
    axi_wr(`OFS_ENABLE_A, 32'h0000_0084);
    axi_wr(`OFS_ENABLE_B, 32'h0000_001B);
    axi_wr(`OFS_PRIO_LOW_A, 32'h0000_0004);
    axi_wr(`OFS_PRIO_LOW_B, 32'h0000_0019);
    axi_wr(`OFS_PRIO_HIGH_B, 32'h0000_001A);
    set_req(src_vec_t'(13'h0004), 1'b1);
    wait_take(8'h01);
    set_req(src_vec_t'(13'h0080), 1'b1);
    idle(20);
    check("equal waits", 32'(takenCnt), 32'h0000_0001);
    set_req(src_vec_t'(13'h0180), 1'b1);
    wait_take(8'h02);
    check("higher preempts", 32'(takenId), 32'h0000_0008);
    set_req(src_vec_t'(13'h0080), 1'b1);
    ret_pulse();
    idle(20);
    check("after return", 32'(takenCnt), 32'h0000_0002);
    ret_pulse();
    wait_take(8'h03);
    check("resumed id", 32'(takenId), 32'h0000_0007);
    set_req(src_vec_t'(13'h0480), 1'b1);
    wait_take(8'h04);
    check("top entered", 32'(takenId), 32'h0000_000A);
    set_req(src_vec_t'(13'h0D80), 1'b1);
    idle(20);
    check("top kept", 32'(takenCnt), 32'h0000_0004);
  endtask

  // External pins in level and edge mode
  task automatic t_ext;
    set_req(src_vec_t'(13'h0001), 1'b0);
    idle(8);
    axi_rd(`OFS_TIMER_CONTROL);
    check("level no flag", rd, 32'h0000_0000);
    set_req(src_vec_t'(13'h0000), 1'b0);
    axi_wr(`OFS_TIMER_CONTROL, 32'h0000_0001);
    set_req(src_vec_t'(13'h0001), 1'b0);
    idle(8);
    axi_rd(`OFS_TIMER_CONTROL);
    check("edge flag", rd, 32'h0000_0003);
    set_req(src_vec_t'(13'h0002), 1'b0);
    idle(8);
    axi_rd(`OFS_PENDING);
    check("level asserted", 32'(rd[1]), 32'h0000_0001);
    set_req(src_vec_t'(13'h0000), 1'b0);
    idle(8);
    axi_rd(`OFS_PENDING);
    check("level removed", 32'(rd[1]), 32'h0000_0000);
    axi_wr(`OFS_TIMER_CONTROL, 32'h0000_0005);
    set_req(src_vec_t'(13'h0002), 1'b0);
    idle(8);
    axi_rd(`OFS_TIMER_CONTROL);
    check("edge flag b", rd, 32'h0000_000D);
  endtask

  // Wake from Power-down by a pin, from Idle by a peripheral
  task automatic t_wake(input logic pd, input src_vec_t v);
    axi_wr(`OFS_ENABLE_A, {24'h0, 1'b1, v[6:0]});
    @(posedge core_clk);
    sleepPdown <= pd;
    sleepIdle <= !pd;
    @(posedge core_clk);
    sleepPdown <= 1'b0;
    sleepIdle <= 1'b0;
    set_req(v, 1'b0);
    idle(10);
    @(negedge core_clk);
    check("wake count", 32'(wakeCnt), 32'h0000_0001);
  endtask

  // Sticky status, mask and the level interrupt
  task automatic t_irq;
    set_req(src_vec_t'(13'h0010), 1'b0);
    idle(5);
    @(negedge core_clk);
    check("irq masked", 32'(irq), 32'h0000_0000);
    axi_wr(`OFS_MASK, 32'h0000_1FFF);
    idle(3);
    @(negedge core_clk);
    check("irq raised", 32'(irq), 32'h0000_0001);
    set_req(src_vec_t'(13'h0000), 1'b0);
    idle(2);
    axi_rd(`OFS_STATUS);
    check("status bit", 32'(rd[4]), 32'h0000_0001);
    idle(2);
    @(negedge core_clk);
    check("irq cleared", 32'(irq), 32'h0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset();
    t_sources();
    do_reset();
    t_enable();
    do_reset();
    t_prio();
    do_reset();
    t_preempt();
    do_reset();
    t_ext();
    do_reset();
    t_wake(1'b1, src_vec_t'(13'h0001));
    do_reset();
    t_wake(1'b0, src_vec_t'(13'h0008));
    do_reset();
    t_irq();
    finish_test();
  end

  // Watchdog against a hung handshake
  initial begin
    #2_000_000;
    badCount++;
    finish_test();
  end
endmodule
